// ---- pnvm_port.sv ----
`timescale 1ns/100ps
// Notes on behaviour
// - Code 68h programs code, 0000h-7FFFh
// - Code 69h programs setup bytes FFF8h/FFF9h
// - Code 6Bh programs lock bits 1-3
// - Code 6Ch programs key array 00h-7Fh
// - Code 28h verifies code memory
// - Device drives addressed byte on setup verify; code verify drives it XNORed with key byte
// - Code 29h verifies setup bytes
// - Code 29h reads identification bytes
// - Key array never readable
// - Identification bytes never writable
// - Code verify XNORed with key byte
// - Lock level 1+ blocks code/key/setup programming; level 2+ blocks code verify
// - Lock byte low bits give level
module pnvm_port
    import pnvm_pkg::*;
#(
    parameter int unsigned CODE_AW = 15,
    parameter logic [7:0]  ID_BYTE0 = 8'h11, // Arbitrary identification value
    parameter logic [7:0]  ID_BYTE1 = 8'h22, // Arbitrary identification value
    parameter logic [7:0]  ID_BYTE2 = 8'h33, // Arbitrary identification value
    parameter logic [7:0]  ID_BYTE3 = 8'h44  // Arbitrary identification value
) (
    // Clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    // Programming pins
    input  wire logic       device_reset_i,
    input  wire logic       program_store_strobe_n_i,
    input  wire logic       latch_program_pin_n_i,
    input  wire logic       high_voltage_enable_pin_i,
    input  wire logic [7:0] mode_code_port_i,
    input  wire logic [7:0] addr_high_port_i,
    input  wire logic [7:0] addr_low_port_i,
    // Data port, two-way
    input  wire logic [7:0] data_port_i,
    output logic      [7:0] data_port_o,
    output logic            data_port_oe_o,
    // Status
    output logic      [2:0] lock_level_o,
    output logic            prog_active_o
);
    // The address decode below assumes a 32-kilobyte code array
    if (CODE_AW != 15) begin : g_bad_code_aw
        $error("pnvm_port: code array must span 0000h-7FFFh");
    end

    typedef enum logic [2:0] {
        PNVM_IDLE  = 3'b001,
        PNVM_ARMED = 3'b010,
        PNVM_OPER  = 3'b100
    } pnvm_state_type;

    function automatic logic [1:0] lock_level(input logic [2:0] lb);
        if (lb[2])      lock_level = 2'd3;
        else if (lb[1]) lock_level = 2'd2;
        else if (lb[0]) lock_level = 2'd1;
        else            lock_level = 2'd0;
    endfunction : lock_level

    pnvm_state_type state_q, state_d;
    logic [1:0]  hi_cnt_q, hi_cnt_d;
    // Latch level one edge back; a pin held low must not write a second time
    logic        latch_q, latch_d;
    logic [7:0]  setup_lo_q, setup_lo_d, setup_hi_q, setup_hi_d;
    logic [2:0]  lock_q, lock_d;
    logic [7:0]  dout_q, dout_d;
    logic        oe_q, oe_d;

    logic [15:0] addr;
    logic        pulse;
    logic        code_wr;
    logic [7:0]  code_rd;
    logic        key_wr;
    logic [7:0]  key_rd;
    logic [1:0]  level;

    assign addr  = {addr_high_port_i, addr_low_port_i};
    assign level = lock_level(lock_q);
    // Falling edge of latch while operating; one write per pulse
    assign pulse = (state_q == PNVM_OPER) && latch_q && !latch_program_pin_n_i
                   && high_voltage_enable_pin_i;
    assign code_wr = pulse && mode_code_port_i == PNVM_OP_PROG_CODE
                     && addr <= PNVM_CODE_LAST && level == 2'd0;
    assign key_wr  = pulse && mode_code_port_i == PNVM_OP_PROG_KEY
                     && addr <= PNVM_KEY_LAST && level == 2'd0;

    pnvm_mem #(.AW(CODE_AW), .DW(8)) u_code (
        .core_clk_i (core_clk_i),
        .wr_en_i    (code_wr),
        .wr_addr_i  (addr[14:0]),
        .wr_data_i  (data_port_i),
        .rd_addr_i  (addr[14:0]),
        .rd_data_o  (code_rd)
    );

    // Key bytes keep their own array; its read register lines up with the code read
    pnvm_mem #(.AW(7), .DW(8)) u_key (
        .core_clk_i (core_clk_i),
        .wr_en_i    (key_wr),
        .wr_addr_i  (addr[6:0]),
        .wr_data_i  (data_port_i),
        .rd_addr_i  (addr[6:0]),
        .rd_data_o  (key_rd)
    );

    always_comb begin
        state_d  = state_q;
        hi_cnt_d = hi_cnt_q;
        case (state_q)
            PNVM_IDLE: begin
                // Entry needs reset held and strobe high for setup cycles
                if (device_reset_i && program_store_strobe_n_i && latch_program_pin_n_i) begin
                    if (hi_cnt_q < 2'(PNVM_SETUP_CYCLES - 1)) hi_cnt_d = hi_cnt_q + 2'd1;
                    else state_d = PNVM_ARMED;
                end else begin
                    hi_cnt_d = 2'd0;
                end
            end
            PNVM_ARMED: begin
                if (!device_reset_i) state_d = PNVM_IDLE;
                else if (!program_store_strobe_n_i) state_d = PNVM_OPER;
            end
            PNVM_OPER: begin
                // Releasing strobe or reset ends the sequence
                if (!device_reset_i || program_store_strobe_n_i) begin
                    state_d  = PNVM_IDLE;
                    hi_cnt_d = 2'd0;
                end
            end
            default: state_d = PNVM_IDLE;
        endcase
    end

    always_comb begin
        latch_d    = latch_program_pin_n_i;
        setup_lo_d = setup_lo_q;
        setup_hi_d = setup_hi_q;
        lock_d     = lock_q;
        // Identification bytes have no write path
        if (pulse) begin
            case (mode_code_port_i)
                PNVM_OP_PROG_SETUP: begin
                    if (level == 2'd0) begin
                        if (addr == PNVM_SETUP_LO_ADDR) setup_lo_d = setup_lo_q & data_port_i;
                        if (addr == PNVM_SETUP_HI_ADDR) setup_hi_d = setup_hi_q & data_port_i;
                    end
                end
                PNVM_OP_PROG_LOCK: begin
                    // Lock bits always programmable; data ignored
                    if (addr == PNVM_LOCK0_ADDR) lock_d[0] = 1'b1;
                    if (addr == PNVM_LOCK1_ADDR) lock_d[1] = 1'b1;
                    if (addr == PNVM_LOCK2_ADDR) lock_d[2] = 1'b1;
                end
                // Key bytes are written through the key array's own port
                default: ;
            endcase
        end
    end

    // Verify answers; code data arrives one cycle after the address
    // The port is released at the clock edge after the programming voltage comes up
    always_comb begin
        dout_d = 8'h00;
        oe_d   = 1'b0;
        if (state_q == PNVM_OPER && latch_program_pin_n_i && !high_voltage_enable_pin_i) begin
            case (mode_code_port_i)
                PNVM_OP_VFY_CODE: begin
                    if (addr <= PNVM_CODE_LAST && level < 2'd2) begin
                        dout_d = ~(code_rd ^ key_rd);
                        oe_d   = 1'b1;
                    end
                end
                PNVM_OP_VFY_SETUP: begin
                    oe_d = 1'b1;
                    if (addr == PNVM_SETUP_LO_ADDR)      dout_d = setup_lo_q;
                    else if (addr == PNVM_SETUP_HI_ADDR) dout_d = setup_hi_q;
                    else if (addr == PNVM_ID0_ADDR)      dout_d = ID_BYTE0;
                    else if (addr == PNVM_ID1_ADDR)      dout_d = ID_BYTE1;
                    else if (addr == PNVM_ID2_ADDR)      dout_d = ID_BYTE2;
                    else if (addr == PNVM_ID3_ADDR)      dout_d = ID_BYTE3;
                    else                                 oe_d   = 1'b0;
                end
                PNVM_OP_VFY_LOCK: begin
                    if (addr == PNVM_LOCK_VFY_ADDR) begin
                        dout_d = {5'h00, lock_q};
                        oe_d   = 1'b1;
                    end
                end
                // Key array has no verify code at all
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q    <= PNVM_IDLE;
            hi_cnt_q   <= 2'd0;
            latch_q    <= 1'b1;
            setup_lo_q <= PNVM_ERASED;
            setup_hi_q <= PNVM_ERASED;
            lock_q     <= PNVM_LOCK_RESET;
            dout_q     <= 8'h00;
            oe_q       <= 1'b0;
        end else begin
            state_q    <= state_d;
            hi_cnt_q   <= hi_cnt_d;
            latch_q    <= latch_d;
            setup_lo_q <= setup_lo_d;
            setup_hi_q <= setup_hi_d;
            lock_q     <= lock_d;
            dout_q     <= dout_d;
            oe_q       <= oe_d;
        end
    end

    assign data_port_o    = dout_q;
    assign data_port_oe_o = oe_q;
    assign lock_level_o   = lock_q;
    assign prog_active_o  = (state_q == PNVM_OPER);

    level_block_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        code_wr |-> lock_q == 3'h0)
        else $error("code write while locked");
    one_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        pulse |=> !pulse)
        else $error("two writes in one latch pulse");
    key_hidden_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (mode_code_port_i == PNVM_OP_PROG_KEY) |=> !oe_q)
        else $error("data driven in key mode");
    lock_read_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (state_q == PNVM_OPER && latch_program_pin_n_i && !high_voltage_enable_pin_i
         && mode_code_port_i == PNVM_OP_VFY_LOCK && addr == PNVM_LOCK_VFY_ADDR)
        |=> oe_q && data_port_o == {5'h00, $past(lock_q)})
        else $error("lock verify wrong");
    verify_block_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (mode_code_port_i == PNVM_OP_VFY_CODE && level >= 2'd2) |=> !oe_q)
        else $error("code verify while level two");
    unknown_code_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (mode_code_port_i == 8'h00) |=> !oe_q)
        else $error("data driven for unknown code");
    idle_quiet_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (state_q != PNVM_OPER) |=> !oe_q)
        else $error("data driven outside a sequence");
    lock_sticky_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (lock_q & ~$past(lock_q)) == 3'h0 || $past(pulse))
        else $error("lock bit set without pulse");

    // Setup and lock bytes move only on a latch pulse; setup bytes never once locked
    setup_guard_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (lock_q != 3'h0) |=> setup_lo_q == $past(setup_lo_q) && setup_hi_q == $past(setup_hi_q))
        else $error("setup byte changed while locked");
    setup_quiet_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !pulse |=> $stable(setup_lo_q) && $stable(setup_hi_q) && $stable(lock_q))
        else $error("stored byte changed without pulse");
    hv_quiet_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        high_voltage_enable_pin_i |=> !oe_q)
        else $error("data driven at programming voltage");

    // Verify answers one cycle after the request
    setup_read_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (state_q == PNVM_OPER && latch_program_pin_n_i && !high_voltage_enable_pin_i
         && mode_code_port_i == PNVM_OP_VFY_SETUP && addr == PNVM_SETUP_LO_ADDR)
        |=> oe_q && data_port_o == $past(setup_lo_q))
        else $error("setup verify wrong");
    ident_read_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (state_q == PNVM_OPER && latch_program_pin_n_i && !high_voltage_enable_pin_i
         && mode_code_port_i == PNVM_OP_VFY_SETUP && addr == PNVM_ID2_ADDR)
        |=> oe_q && data_port_o == ID_BYTE2)
        else $error("identification verify wrong");
    code_range_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (state_q == PNVM_OPER && latch_program_pin_n_i && !high_voltage_enable_pin_i
         && mode_code_port_i == PNVM_OP_VFY_CODE && addr > PNVM_CODE_LAST)
        |=> !oe_q)
        else $error("code verify outside array");
    lock_addr_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (state_q == PNVM_OPER && latch_program_pin_n_i && !high_voltage_enable_pin_i
         && mode_code_port_i == PNVM_OP_VFY_LOCK && addr != PNVM_LOCK_VFY_ADDR)
        |=> !oe_q)
        else $error("lock verify at wrong address");

    // Sequence entry and exit
    oper_entry_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        $rose(prog_active_o) |-> !$past(program_store_strobe_n_i) && $past(device_reset_i))
        else $error("sequence entered without strobe");
    oper_exit_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (prog_active_o && program_store_strobe_n_i) |=> !prog_active_o)
        else $error("sequence kept after strobe release");
    reset_exit_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !device_reset_i |=> !prog_active_o)
        else $error("sequence active without chip reset");

endmodule : pnvm_port

// ---- pnvm_pkg.sv ----
package pnvm_pkg;

    // Operation codes on the mode code port
    localparam logic [7:0] PNVM_OP_PROG_CODE   = 8'h68;
    localparam logic [7:0] PNVM_OP_PROG_SETUP  = 8'h69;
    localparam logic [7:0] PNVM_OP_PROG_LOCK   = 8'h6b;
    localparam logic [7:0] PNVM_OP_PROG_KEY    = 8'h6c;
    localparam logic [7:0] PNVM_OP_VFY_CODE    = 8'h28;
    localparam logic [7:0] PNVM_OP_VFY_SETUP   = 8'h29;
    localparam logic [7:0] PNVM_OP_VFY_LOCK    = 8'h2b;

    // Address map
    localparam logic [15:0] PNVM_CODE_LAST     = 16'h7fff;
    localparam logic [15:0] PNVM_KEY_LAST      = 16'h007f;
    localparam logic [15:0] PNVM_SETUP_LO_ADDR = 16'hfff8;
    localparam logic [15:0] PNVM_SETUP_HI_ADDR = 16'hfff9;
    localparam logic [15:0] PNVM_LOCK0_ADDR    = 16'h0001;
    localparam logic [15:0] PNVM_LOCK1_ADDR    = 16'h0002;
    localparam logic [15:0] PNVM_LOCK2_ADDR    = 16'h0003;
    localparam logic [15:0] PNVM_LOCK_VFY_ADDR = 16'h0000;
    localparam logic [15:0] PNVM_ID0_ADDR      = 16'h0030;
    localparam logic [15:0] PNVM_ID1_ADDR      = 16'h0031;
    localparam logic [15:0] PNVM_ID2_ADDR      = 16'h0060;
    localparam logic [15:0] PNVM_ID3_ADDR      = 16'h0061;

    // Erased cell value and reset values
    localparam logic [7:0] PNVM_ERASED         = 8'hff;
    localparam logic [2:0] PNVM_LOCK_RESET     = 3'h0;

    // Strobe must be seen high for this many cycles before it counts as low
    localparam int unsigned PNVM_SETUP_CYCLES  = 2;

endpackage : pnvm_pkg

// ---- pnvm_mem.sv ----
`timescale 1ns/100ps
module pnvm_mem
    import pnvm_pkg::*;
#(
    parameter int unsigned AW = 15,
    parameter int unsigned DW = 8
) (
    // Clock
    input  wire logic          core_clk_i,
    // Write port
    input  wire logic          wr_en_i,
    input  wire logic [AW-1:0] wr_addr_i,
    input  wire logic [DW-1:0] wr_data_i,
    // Read port
    input  wire logic [AW-1:0] rd_addr_i,
    output logic      [DW-1:0] rd_data_o
);
    // Cells start erased; programming can only clear bits, like the real array
    logic [DW-1:0] cells [0:(1<<AW)-1];

    initial begin
        for (int i = 0; i < (1 << AW); i++) begin
            cells[i] = '1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (wr_en_i) begin
            cells[wr_addr_i] <= cells[wr_addr_i] & wr_data_i;
        end
        rd_data_o <= cells[rd_addr_i];
    end

endmodule : pnvm_mem

// ---- pnvm_prog_model.sv ----
`timescale 1ns/100ps
module pnvm_prog_model (
    // Clock
    input  wire logic       core_clk_i,
    // Control pins toward the device
    output logic            device_reset_o,
    output logic            program_store_strobe_n_o,
    output logic            latch_program_pin_n_o,
    output logic            high_voltage_enable_pin_o,
    // Code, address and data
    output logic      [7:0] mode_code_port_o,
    output logic      [7:0] addr_high_port_o,
    output logic      [7:0] addr_low_port_o,
    output logic      [7:0] data_port_o
);
    initial begin
        device_reset_o            = 1'b0;
        program_store_strobe_n_o  = 1'b1;
        latch_program_pin_n_o     = 1'b1;
        high_voltage_enable_pin_o = 1'b0;
        mode_code_port_o          = 8'hff;
        addr_high_port_o          = 8'h00;
        addr_low_port_o           = 8'h00;
        data_port_o               = 8'h00;
    end

    task automatic open_seq();
        @(posedge core_clk_i);
        device_reset_o <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        program_store_strobe_n_o <= 1'b0;
    endtask : open_seq

    task automatic close_seq();
        @(posedge core_clk_i);
        program_store_strobe_n_o <= 1'b1;
        mode_code_port_o         <= 8'hff;
        repeat (3) @(posedge core_clk_i);
        device_reset_o <= 1'b0;
    endtask : close_seq

    // Data is changed to d2 while the latch is still low to catch repeated writes
    task automatic prog(input logic [7:0] m, input logic [15:0] a, input logic [7:0] d, input logic [7:0] d2);
        @(posedge core_clk_i);
        mode_code_port_o <= m;
        addr_high_port_o <= a[15:8];
        addr_low_port_o  <= a[7:0];
        data_port_o      <= d;
        @(posedge core_clk_i);
        high_voltage_enable_pin_o <= 1'b1;
        @(posedge core_clk_i);
        latch_program_pin_n_o <= 1'b0;
        @(posedge core_clk_i);
        data_port_o <= d2;
        @(posedge core_clk_i);
        latch_program_pin_n_o <= 1'b1;
        @(posedge core_clk_i);
        high_voltage_enable_pin_o <= 1'b0;
        @(posedge core_clk_i);
    endtask : prog

    // Released data lines show the inverse of the last value, never a stale copy
    task automatic vfy(input logic [7:0] m, input logic [15:0] a);
        @(posedge core_clk_i);
        mode_code_port_o <= m;
        addr_high_port_o <= a[15:8];
        addr_low_port_o  <= a[7:0];
        data_port_o      <= ~data_port_o;
        repeat (4) @(posedge core_clk_i);
        #1;
    endtask : vfy
endmodule : pnvm_prog_model

// ---- pnvm_port_tb.sv ----
`timescale 1ns/100ps
module pnvm_port_tb;
    import pnvm_pkg::*;
    localparam logic [7:0]  IDV [4] = '{8'h11, 8'h22, 8'h33, 8'h44}; // Arbitrary identification values
    localparam logic [15:0] IDA [4] = '{PNVM_ID0_ADDR, PNVM_ID1_ADDR, PNVM_ID2_ADDR, PNVM_ID3_ADDR};
    localparam logic [7:0]  BAD [4] = '{8'h6c, 8'h2c, 8'h00, 8'hff};
    logic       core_clk_i = 1'b0;
    logic       rst_n_i    = 1'b0;
    logic       dev_rst;
    logic       strobe_n;
    logic       latch_n;
    logic       hv;
    logic [7:0] mode;
    logic [7:0] ah;
    logic [7:0] al;
    logic [7:0] prog_data;
    logic [7:0] dp_in;
    logic [7:0] dp_out;
    logic       dp_oe;
    logic [2:0] lock_lvl;
    logic       active;
    int         err_total    = 0;
    int         total_checks = 0;
    int         i;

    always #50 core_clk_i = ~core_clk_i;
    assign dp_in = dp_oe ? dp_out : prog_data;

    pnvm_port #(.ID_BYTE0(IDV[0]), .ID_BYTE1(IDV[1]), .ID_BYTE2(IDV[2]), .ID_BYTE3(IDV[3])) u_pnvm_port (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .device_reset_i(dev_rst),
        .program_store_strobe_n_i(strobe_n), .latch_program_pin_n_i(latch_n),
        .high_voltage_enable_pin_i(hv), .mode_code_port_i(mode), .addr_high_port_i(ah),
        .addr_low_port_i(al), .data_port_i(dp_in), .data_port_o(dp_out), .data_port_oe_o(dp_oe),
        .lock_level_o(lock_lvl), .prog_active_o(active));

    pnvm_prog_model u_pnvm_prog_model (
        .core_clk_i(core_clk_i), .device_reset_o(dev_rst), .program_store_strobe_n_o(strobe_n),
        .latch_program_pin_n_o(latch_n), .high_voltage_enable_pin_o(hv), .mode_code_port_o(mode),
        .addr_high_port_o(ah), .addr_low_port_o(al), .data_port_o(prog_data));

    task automatic results();
        $display("Checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic rd(input logic [7:0] m, input logic [15:0] a, input logic [7:0] exp, input logic [7:0] msk);
        u_pnvm_prog_model.vfy(m, a);
        chk("verify enable", {7'h00, dp_oe}, 8'h01);
        chk("verify data", dp_out & msk, exp);
    endtask : rd

    task automatic no_rd(input logic [7:0] m, input logic [15:0] a);
        u_pnvm_prog_model.vfy(m, a);
        chk("refused enable", {7'h00, dp_oe}, 8'h00);
    endtask : no_rd

    task automatic wait_active(input logic exp);
        for (i = 0; i < 10 && active !== exp; i++) begin
            @(posedge core_clk_i);
            #1;
        end
        chk("sequence active", {7'h00, active}, {7'h00, exp});
        if (active !== exp) results();
    endtask : wait_active

    initial begin
        repeat (4) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        u_pnvm_prog_model.open_seq();
        wait_active(1'b1);
        u_pnvm_prog_model.prog(PNVM_OP_PROG_CODE, 16'h7fff, 8'ha5, 8'ha5);
        rd(PNVM_OP_VFY_CODE, 16'h7fff, 8'ha5, 8'hff);
        u_pnvm_prog_model.prog(PNVM_OP_PROG_CODE, 16'h0000, 8'hf0, 8'h0f);
        rd(PNVM_OP_VFY_CODE, 16'h0000, 8'hf0, 8'hff);
        u_pnvm_prog_model.prog(PNVM_OP_PROG_KEY, 16'h007f, 8'h0f, 8'h0f);
        rd(PNVM_OP_VFY_CODE, 16'h7fff, 8'h55, 8'hff);
        u_pnvm_prog_model.prog(PNVM_OP_PROG_SETUP, PNVM_SETUP_LO_ADDR, 8'h3c, 8'h3c);
        rd(PNVM_OP_VFY_SETUP, PNVM_SETUP_LO_ADDR, 8'h3c, 8'hff);
        rd(PNVM_OP_VFY_SETUP, PNVM_SETUP_HI_ADDR, 8'hff, 8'hff);
        u_pnvm_prog_model.prog(PNVM_OP_PROG_SETUP, PNVM_ID0_ADDR, 8'h00, 8'h00);
        foreach (IDA[k]) rd(PNVM_OP_VFY_SETUP, IDA[k], IDV[k], 8'hff);
        foreach (BAD[k]) no_rd(BAD[k], 16'h007f);
        no_rd(PNVM_OP_VFY_CODE, 16'h8000);
        chk("lock level", {5'h00, lock_lvl}, 8'h00);
        u_pnvm_prog_model.prog(PNVM_OP_PROG_LOCK, PNVM_LOCK0_ADDR, 8'h00, 8'h00);
        chk("lock level", {5'h00, lock_lvl}, 8'h01);
        rd(PNVM_OP_VFY_LOCK, PNVM_LOCK_VFY_ADDR, 8'h01, 8'h07);
        no_rd(PNVM_OP_VFY_LOCK, PNVM_LOCK0_ADDR);
        u_pnvm_prog_model.prog(PNVM_OP_PROG_CODE, 16'h0020, 8'h00, 8'h00);
        u_pnvm_prog_model.prog(PNVM_OP_PROG_KEY, 16'h0020, 8'h00, 8'h00);
        u_pnvm_prog_model.prog(PNVM_OP_PROG_SETUP, PNVM_SETUP_HI_ADDR, 8'h00, 8'h00);
        rd(PNVM_OP_VFY_CODE, 16'h0020, 8'hff, 8'hff);
        rd(PNVM_OP_VFY_SETUP, PNVM_SETUP_HI_ADDR, 8'hff, 8'hff);
        u_pnvm_prog_model.prog(PNVM_OP_PROG_LOCK, PNVM_LOCK1_ADDR, 8'h00, 8'h00);
        chk("lock level", {5'h00, lock_lvl}, 8'h03);
        rd(PNVM_OP_VFY_LOCK, PNVM_LOCK_VFY_ADDR, 8'h02, 8'h06);
        no_rd(PNVM_OP_VFY_CODE, 16'h7fff);
        rd(PNVM_OP_VFY_SETUP, PNVM_SETUP_LO_ADDR, 8'h3c, 8'hff);
        u_pnvm_prog_model.prog(PNVM_OP_PROG_LOCK, PNVM_LOCK2_ADDR, 8'h00, 8'h00);
        rd(PNVM_OP_VFY_LOCK, PNVM_LOCK_VFY_ADDR, 8'h04, 8'h04);
        u_pnvm_prog_model.close_seq();
        wait_active(1'b0);
        results();
    end
endmodule : pnvm_port_tb
